// File: verilog/adc_conversion_control.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module adc_conversion_control #(
  parameter int FIFO_DEPTH = 2,
  parameter int AVG_SAMPLES = 4,
  parameter int GAIN_W = 4
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // AXI4-Lite slave
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Analog front end
  output logic ADC_POWER_O,
  output logic MOD_CLK_O,
  output logic [adc_ctrl_pkg::CH_W-1:0] MUX_SEL_O,
  output logic DC_CHANNEL_SWITCH_CLOCK_O,
  output logic ACQUIRE_O,
  output logic CONV_START_O,
  output logic AUDIO_MODE_O,
  output logic [GAIN_W-1:0] PROGRAMMABLE_GAIN_STAGE_O,
  output logic HIGH_INPUT_RANGE_O,
  output logic RECAL_O,
  input wire logic CONV_DONE_I,
  input wire logic [adc_ctrl_pkg::AUD_W-1:0] CONV_DATA_I,
  // Audio DMA stream
  output logic [adc_ctrl_pkg::AUD_W-1:0] DMA_DATA_O,
  output logic DMA_VALID_O,
  input wire logic DMA_READY_I
);

  localparam int AVG_SH = $clog2(AVG_SAMPLES);
  localparam int ACC_W = adc_ctrl_pkg::DC_W + AVG_SH;
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [AVG_SH:0] AVG_LAST = (AVG_SH + 1)'(AVG_SAMPLES - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] done_sync_reg;
  logic [adc_ctrl_pkg::AUD_W-1:0] data_sync_reg [3];
  logic done_lvl_reg;
  logic done_rise;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      done_sync_reg <= 3'h0;
      data_sync_reg[0] <= 12'h000;
      data_sync_reg[1] <= 12'h000;
      data_sync_reg[2] <= 12'h000;
      done_lvl_reg <= 1'b0;
    end
    else
    begin
      done_sync_reg <= {done_sync_reg[1:0], CONV_DONE_I};
      data_sync_reg[0] <= CONV_DATA_I;
      data_sync_reg[1] <= data_sync_reg[0];
      data_sync_reg[2] <= data_sync_reg[1];
      if (done_sync_reg[1] == done_sync_reg[2])
      begin
        done_lvl_reg <= done_sync_reg[2];
      end
    end
  end

  // A change counts only once stages two and three agree
  assign done_rise = done_sync_reg[1] & done_sync_reg[2] & ~done_lvl_reg;

  // ****************************************
  // Declarations shared by the groups
  // ****************************************
  adc_ctrl_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic [adc_ctrl_pkg::CH_W-1:0] chan_reg, chan_next;
  logic [GAIN_W-1:0] gain_reg, gain_next;
  adc_ctrl_pkg::rd_t rpend_reg, rpend_next;
  logic avg_reg, avg_next;
  adc_ctrl_pkg::state_t state_reg, state_next;
  logic [adc_ctrl_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [AVG_SH:0] samp_reg, samp_next;
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic [adc_ctrl_pkg::DC_W-1:0] res_reg, res_next;
  logic [adc_ctrl_pkg::CH_W-1:0] mux_reg, mux_next;
  logic muxv_reg, muxv_next, ready_reg, ready_next, tout_reg, tout_next;
  logic range_q_reg, recal_reg, recal_next, modclk_reg;
  logic sw_reg, acq_reg, conv_reg, pwr_reg;
  logic dc_done, push, pop, flush, fifo_in_ready, fifo_out_valid, dma_sel;
  logic [adc_ctrl_pkg::DC_W-1:0] sample10;
  logic [adc_ctrl_pkg::AUD_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [LVL_W-1:0] lvl_reg, lvl_next;

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // DC results keep the upper 10 of the 12 modulator bits
  assign sample10 = data_sync_reg[2][adc_ctrl_pkg::AUD_W-1 -: adc_ctrl_pkg::DC_W];

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    samp_next = samp_reg;
    acc_next = acc_reg;
    res_next = res_reg;
    mux_next = mux_reg;
    muxv_next = muxv_reg;
    ready_next = ready_reg;
    tout_next = tout_reg;
    recal_next = 1'b0;
    dc_done = 1'b0;
    push = 1'b0;
    if (ctrl_reg.high_range != range_q_reg && state_reg != adc_ctrl_pkg::ST_OFF)
    begin
      // Recalibration restarts the reference wait
      recal_next = 1'b1;
      ready_next = 1'b0;
      state_next = adc_ctrl_pkg::ST_REF;
      cnt_next = adc_ctrl_pkg::REF_CYC;
    end
    else
    begin
      case (state_reg)
        adc_ctrl_pkg::ST_OFF:
        begin
          if (ctrl_reg.init)
          begin
            state_next = adc_ctrl_pkg::ST_REF;
            cnt_next = adc_ctrl_pkg::REF_CYC;
          end
        end
        adc_ctrl_pkg::ST_REF:
        begin
          if (cnt_reg == 12'h001)
          begin
            state_next = adc_ctrl_pkg::ST_IDLE;
            ready_next = 1'b1;
          end
          else
          begin
            cnt_next = cnt_reg - 12'h001;
          end
        end
        adc_ctrl_pkg::ST_IDLE:
        begin
          if (ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO)
          begin
            // No conversion starts without room for its result
            if (fifo_in_ready)
            begin
              state_next = adc_ctrl_pkg::ST_CONV;
              cnt_next = adc_ctrl_pkg::CONV_MAX_CYC;
            end
          end
          else if (rpend_reg == adc_ctrl_pkg::RD_DC)
          begin
            samp_next = avg_reg ? AVG_LAST : '0;
            acc_next = '0;
            if (!muxv_reg || mux_reg != chan_reg)
            begin
              mux_next = chan_reg;
              muxv_next = 1'b1;
              state_next = adc_ctrl_pkg::ST_SETTLE;
              cnt_next = adc_ctrl_pkg::SETTLE_CYC;
            end
            else
            begin
              state_next = adc_ctrl_pkg::ST_ACQ;
              cnt_next = adc_ctrl_pkg::ACQ_CYC;
            end
          end
        end
        adc_ctrl_pkg::ST_SETTLE:
        begin
          if (cnt_reg == 12'h001)
          begin
            state_next = adc_ctrl_pkg::ST_ACQ;
            cnt_next = adc_ctrl_pkg::ACQ_CYC;
          end
          else
          begin
            cnt_next = cnt_reg - 12'h001;
          end
        end
        adc_ctrl_pkg::ST_ACQ:
        begin
          if (cnt_reg == 12'h001)
          begin
            state_next = adc_ctrl_pkg::ST_CONV;
            cnt_next = adc_ctrl_pkg::CONV_MAX_CYC;
          end
          else
          begin
            cnt_next = cnt_reg - 12'h001;
          end
        end
        adc_ctrl_pkg::ST_CONV:
        begin
          // A late modulator is cut off so no conversion lasts longer than 20 us
          if (done_rise || cnt_reg == 12'h001)
          begin
            tout_next = !done_rise;
            if (ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO)
            begin
              push = done_rise;
              state_next = adc_ctrl_pkg::ST_IDLE;
            end
            else
            begin
              acc_next = acc_reg + ACC_W'(done_rise ? sample10 : 10'h000);
              if (samp_reg == '0)
              begin
                dc_done = 1'b1;
                res_next = avg_reg ? adc_ctrl_pkg::DC_W'(acc_next >> AVG_SH) :
                  (done_rise ? sample10 : 10'h000);
                state_next = adc_ctrl_pkg::ST_IDLE;
              end
              else
              begin
                samp_next = samp_reg - 1'b1;
                state_next = adc_ctrl_pkg::ST_ACQ;
                cnt_next = adc_ctrl_pkg::ACQ_CYC;
              end
            end
          end
          else
          begin
            cnt_next = cnt_reg - 12'h001;
          end
        end
        default:
        begin
          state_next = adc_ctrl_pkg::ST_OFF;
        end
      endcase
    end
    if (!ctrl_reg.init)
    begin
      // Power-down drops to ST_OFF and clears ready and the mux-valid flag; firmware must initialise again
      state_next = adc_ctrl_pkg::ST_OFF;
      ready_next = 1'b0;
      muxv_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      state_reg <= adc_ctrl_pkg::ST_OFF;
      cnt_reg <= '0;
      samp_reg <= '0;
      acc_reg <= '0;
      res_reg <= '0;
      mux_reg <= adc_ctrl_pkg::CHAN_RST;
      muxv_reg <= 1'b0;
      ready_reg <= 1'b0;
      tout_reg <= 1'b0;
      range_q_reg <= 1'b0;
      recal_reg <= 1'b0;
      modclk_reg <= 1'b0;
      sw_reg <= 1'b0;
      acq_reg <= 1'b0;
      conv_reg <= 1'b0;
      pwr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      samp_reg <= samp_next;
      acc_reg <= acc_next;
      res_reg <= res_next;
      mux_reg <= mux_next;
      muxv_reg <= muxv_next;
      ready_reg <= ready_next;
      tout_reg <= tout_next;
      range_q_reg <= ctrl_reg.high_range;
      recal_reg <= recal_next;
      modclk_reg <= !modclk_reg;
      sw_reg <= (state_next == adc_ctrl_pkg::ST_SETTLE);
      acq_reg <= (state_next == adc_ctrl_pkg::ST_ACQ);
      conv_reg <= (state_next == adc_ctrl_pkg::ST_CONV);
      pwr_reg <= (state_next != adc_ctrl_pkg::ST_OFF);
    end
  end

  // ****************************************
  // Audio result buffer
  // ****************************************
  assign dma_sel = (ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO) && ctrl_reg.dma_en;
  assign flush = (ctrl_reg.mode != adc_ctrl_pkg::MODE_AUDIO);
  assign fifo_in_ready = (lvl_reg < LVL_W'(FIFO_DEPTH));
  assign fifo_out_valid = (lvl_reg != '0);
  assign pop = fifo_out_valid &&
    (dma_sel ? DMA_READY_I : (rpend_reg == adc_ctrl_pkg::RD_AUDIO));

  always_comb
  begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    lvl_next = lvl_reg;
    if (flush)
    begin
      wptr_next = '0;
      rptr_next = '0;
      lvl_next = '0;
    end
    else
    begin
      if (push)
      begin
        wptr_next = (wptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop)
      begin
        rptr_next = (rptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      lvl_next = lvl_reg + LVL_W'(push) - LVL_W'(pop);
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      lvl_reg <= lvl_next;
    end
    if (push)
    begin
      fifo_mem[wptr_reg] <= data_sync_reg[2];
    end
  end

  // ****************************************
  // AXI4-Lite register slave
  // ****************************************
  logic awv_reg, awv_next, wv_reg, wv_next, bv_reg, bv_next, rv_reg, rv_next;
  logic [adc_ctrl_pkg::ADDR_W-1:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic ws_reg, ws_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic [31:0] status;

  assign S_AXI_AWREADY_O = !awv_reg && !bv_reg;
  assign S_AXI_WREADY_O = !wv_reg && !bv_reg;
  assign S_AXI_ARREADY_O = !rv_reg && (rpend_reg == adc_ctrl_pkg::RD_NONE);

  always_comb
  begin
    status = 32'h0000_0000;
    status[adc_ctrl_pkg::ST_INIT_BIT] = ctrl_reg.init;
    status[adc_ctrl_pkg::ST_READY_BIT] = ready_reg;
    status[adc_ctrl_pkg::ST_BUSY_BIT] = (state_reg != adc_ctrl_pkg::ST_IDLE) &&
      (state_reg != adc_ctrl_pkg::ST_OFF);
    status[adc_ctrl_pkg::ST_TIMEOUT_BIT] = tout_reg;
    status[adc_ctrl_pkg::ST_FIFO_BIT +: LVL_W] = lvl_reg;
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    chan_next = chan_reg;
    gain_next = gain_reg;
    awv_next = awv_reg | (S_AXI_AWVALID_I & S_AXI_AWREADY_O);
    awa_next = (S_AXI_AWVALID_I & S_AXI_AWREADY_O) ? S_AXI_AWADDR_I : awa_reg;
    wv_next = wv_reg | (S_AXI_WVALID_I & S_AXI_WREADY_O);
    wd_next = (S_AXI_WVALID_I & S_AXI_WREADY_O) ? S_AXI_WDATA_I : wd_reg;
    ws_next = (S_AXI_WVALID_I & S_AXI_WREADY_O) ? S_AXI_WSTRB_I[0] : ws_reg;
    bv_next = bv_reg & !S_AXI_BREADY_I;
    br_next = br_reg;
    rv_next = rv_reg & !S_AXI_RREADY_I;
    rd_next = rd_reg;
    rr_next = rr_reg;
    rpend_next = rpend_reg;
    avg_next = avg_reg;
    if (awv_reg && wv_reg)
    begin
      awv_next = 1'b0;
      wv_next = 1'b0;
      bv_next = 1'b1;
      br_next = adc_ctrl_pkg::RESP_OKAY;
      case (awa_reg[adc_ctrl_pkg::ADDR_W-1:2])
        adc_ctrl_pkg::OFF_CTRL[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          if (ws_reg)
          begin
            ctrl_next.init = wd_reg[adc_ctrl_pkg::CTRL_INIT_BIT];
            ctrl_next.mode = adc_ctrl_pkg::mode_t'(wd_reg[adc_ctrl_pkg::CTRL_MODE_BIT]);
            ctrl_next.dma_en = wd_reg[adc_ctrl_pkg::CTRL_DMA_BIT];
            ctrl_next.high_range = wd_reg[adc_ctrl_pkg::CTRL_RANGE_BIT];
          end
        end
        adc_ctrl_pkg::OFF_CHAN[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          if (ws_reg)
          begin
            chan_next = wd_reg[adc_ctrl_pkg::CH_W-1:0];
          end
        end
        adc_ctrl_pkg::OFF_GAIN[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          if (ws_reg)
          begin
            gain_next = wd_reg[GAIN_W-1:0];
          end
        end
        default:
        begin
          br_next = adc_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      rv_next = 1'b1;
      rd_next = 32'h0000_0000;
      rr_next = adc_ctrl_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_I[adc_ctrl_pkg::ADDR_W-1:2])
        adc_ctrl_pkg::OFF_CTRL[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          rd_next[3:0] = ctrl_reg;
        end
        adc_ctrl_pkg::OFF_CHAN[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          rd_next[adc_ctrl_pkg::CH_W-1:0] = chan_reg;
        end
        adc_ctrl_pkg::OFF_GAIN[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          rd_next[GAIN_W-1:0] = gain_reg;
        end
        adc_ctrl_pkg::OFF_STATUS[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          rd_next = status;
        end
        adc_ctrl_pkg::OFF_RAW[adc_ctrl_pkg::ADDR_W-1:2],
        adc_ctrl_pkg::OFF_VOLT[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          // Uninitialised or audio mode answers zero at once
          if (ctrl_reg.init && ctrl_reg.mode == adc_ctrl_pkg::MODE_DC)
          begin
            rv_next = 1'b0;
            rpend_next = adc_ctrl_pkg::RD_DC;
            avg_next = (S_AXI_ARADDR_I[adc_ctrl_pkg::ADDR_W-1:2] ==
              adc_ctrl_pkg::OFF_VOLT[adc_ctrl_pkg::ADDR_W-1:2]);
          end
        end
        adc_ctrl_pkg::OFF_AUDIO[adc_ctrl_pkg::ADDR_W-1:2]:
        begin
          if (ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO && !ctrl_reg.dma_en)
          begin
            rv_next = 1'b0;
            rpend_next = adc_ctrl_pkg::RD_AUDIO;
          end
        end
        default:
        begin
          rr_next = adc_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rpend_reg == adc_ctrl_pkg::RD_DC)
    begin
      if (dc_done || !ctrl_reg.init || ctrl_reg.mode != adc_ctrl_pkg::MODE_DC)
      begin
        rv_next = 1'b1;
        rd_next = {22'h000000, dc_done ? res_next : 10'h000};
        rpend_next = adc_ctrl_pkg::RD_NONE;
      end
    end
    else if (rpend_reg == adc_ctrl_pkg::RD_AUDIO)
    begin
      if (pop || !(ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO && !ctrl_reg.dma_en))
      begin
        rv_next = 1'b1;
        rd_next = {20'h00000, pop ? fifo_mem[rptr_reg] : 12'h000};
        rpend_next = adc_ctrl_pkg::RD_NONE;
      end
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_reg <= adc_ctrl_pkg::CTRL_RST;
      chan_reg <= adc_ctrl_pkg::CHAN_RST;
      gain_reg <= adc_ctrl_pkg::GAIN_RST;
      awv_reg <= 1'b0;
      awa_reg <= '0;
      wv_reg <= 1'b0;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 1'b0;
      bv_reg <= 1'b0;
      br_reg <= adc_ctrl_pkg::RESP_OKAY;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rr_reg <= adc_ctrl_pkg::RESP_OKAY;
      rpend_reg <= adc_ctrl_pkg::RD_NONE;
      avg_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      chan_reg <= chan_next;
      gain_reg <= gain_next;
      awv_reg <= awv_next;
      awa_reg <= awa_next;
      wv_reg <= wv_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      rpend_reg <= rpend_next;
      avg_reg <= avg_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign S_AXI_BVALID_O = bv_reg;
  assign S_AXI_BRESP_O = br_reg;
  assign S_AXI_RVALID_O = rv_reg;
  assign S_AXI_RDATA_O = rd_reg;
  assign S_AXI_RRESP_O = rr_reg;
  assign ADC_POWER_O = pwr_reg;
  assign MOD_CLK_O = modclk_reg;
  assign MUX_SEL_O = mux_reg;
  assign DC_CHANNEL_SWITCH_CLOCK_O = sw_reg;
  assign ACQUIRE_O = acq_reg;
  assign CONV_START_O = conv_reg;
  assign AUDIO_MODE_O = (ctrl_reg.mode == adc_ctrl_pkg::MODE_AUDIO);
  assign PROGRAMMABLE_GAIN_STAGE_O = gain_reg;
  assign HIGH_INPUT_RANGE_O = ctrl_reg.high_range;
  assign RECAL_O = recal_reg;
  assign DMA_VALID_O = dma_sel && fifo_out_valid;
  assign DMA_DATA_O = fifo_mem[rptr_reg];

endmodule : adc_conversion_control

// File: verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int CNT_W = 12;
  localparam int SETTLE_NS = 2000;
  localparam int REF_NS = 20000;
  localparam int ACQ_NS = 10000;
  localparam int CONV_MAX_NS = 20000;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] REF_CYC = CNT_W'((REF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] ACQ_CYC = CNT_W'((ACQ_NS * CLK_MHZ + 999) / 1000);
  // Longest time rounds down
  localparam logic [CNT_W-1:0] CONV_MAX_CYC = CNT_W'((CONV_MAX_NS * CLK_MHZ) / 1000);

  // ****************************************
  // Data and channels
  // ****************************************
  localparam int AUD_W = 12;
  localparam int DC_W = 10;
  localparam int CH_W = 5;
  localparam int NUM_CH = 32;
  localparam int GPIO_CH = 28;
  localparam logic [CH_W-1:0] CH_IO_SUPPLY = 5'h1c;
  localparam logic [CH_W-1:0] CH_CORE_SUPPLY = 5'h1d;
  localparam logic [CH_W-1:0] CH_BANDGAP = 5'h1e;
  localparam logic [CH_W-1:0] CH_REF_GROUND = 5'h1f;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CHAN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GAIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_RAW = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_VOLT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_AUDIO = 8'h18;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_DMA_BIT = 2;
  localparam int CTRL_RANGE_BIT = 3;
  localparam int ST_INIT_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_TIMEOUT_BIT = 3;
  localparam int ST_FIFO_BIT = 4;
  localparam logic [CH_W-1:0] CHAN_RST = 5'h00;
  localparam logic [3:0] GAIN_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {MODE_DC, MODE_AUDIO} mode_t;
  typedef struct packed {
    logic high_range;
    logic dma_en;
    mode_t mode;
    logic init;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '{high_range: 1'b0, dma_en: 1'b0, mode: MODE_DC, init: 1'b0};
  typedef enum logic [2:0] {ST_OFF, ST_REF, ST_IDLE, ST_SETTLE, ST_ACQ, ST_CONV} state_t;
  typedef enum logic [1:0] {RD_NONE, RD_DC, RD_AUDIO} rd_t;

endpackage : adc_ctrl_pkg

// File: verif/adc_conv_sva.sv
`timescale 1ns/1ns
module adc_conv_sva (
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic MOD_CLK_O,
  input wire logic ADC_POWER_O,
  input wire logic DC_CHANNEL_SWITCH_CLOCK_O,
  input wire logic ACQUIRE_O,
  input wire logic CONV_START_O,
  input wire logic AUDIO_MODE_O,
  input wire logic DMA_VALID_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  a_clk_halved: assert property ($past(RST_B_I) |-> MOD_CLK_O != $past(MOD_CLK_O))
    else $error("clock not halved");
  a_dma_audio: assert property (DMA_VALID_O |-> AUDIO_MODE_O)
    else $error("dma outside audio");
  a_settle_len: assert property ($rose(DC_CHANNEL_SWITCH_CLOCK_O) |->
    ##39 DC_CHANNEL_SWITCH_CLOCK_O ##1 !DC_CHANNEL_SWITCH_CLOCK_O) else $error("settle");
  a_acq_len: assert property ($rose(ACQUIRE_O) |-> ##199 ACQUIRE_O ##1 !ACQUIRE_O)
    else $error("acquire");
  a_conv_order: assert property ($rose(CONV_START_O) && !$past(AUDIO_MODE_O) |->
    $past(ACQUIRE_O)) else $error("conv before acquire");
  a_conv_bound: assert property ($rose(CONV_START_O) |-> ##[1:405] !CONV_START_O)
    else $error("conv too long");
  a_ref_wait: assert property ($rose(ADC_POWER_O) |-> ##300 !ACQUIRE_O
    ##100 !DC_CHANNEL_SWITCH_CLOCK_O) else $error("reference wait");
  a_rdata_held: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read answer dropped");
  c_settle: cover property ($rose(DC_CHANNEL_SWITCH_CLOCK_O));
  c_conv: cover property ($fell(CONV_START_O));
  c_dma: cover property (DMA_VALID_O);
endmodule : adc_conv_sva
bind adc_conversion_control adc_conv_sva i_sva (.*);

// File: verif/mod_model.sv
`timescale 1ns/1ns
module mod_model (
  // Clock and request
  input wire logic clk_i,
  input wire logic start_i,
  // Sample and answer delay set by the bench
  input wire logic [11:0] value_i,
  input wire logic [8:0] delay_i,
  // Answer
  output logic done_o,
  output logic [11:0] data_o
);
  int cnt = 0;
  initial
  begin
    done_o = 1'b0;
    data_o = 12'h0;
  end
  // Data is only promised while done is up, so it is scrambled afterwards
  always @(posedge clk_i)
    if (!start_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
      if (done_o)
        data_o <= ~data_o;
    end
    else
    begin
      cnt <= cnt + 1;
      if (cnt == delay_i)
        data_o <= value_i;
      if (cnt == delay_i + 1)
        done_o <= 1'b1;
    end
endmodule : mod_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [1:0] b, rr; logic [31:0] q;} row_t;
  localparam logic [1:0] OK = adc_ctrl_pkg::RESP_OKAY;
  localparam logic [1:0] ER = adc_ctrl_pkg::RESP_SLVERR;
  logic CLK_I = '0, RST_B_I = '0, S_AXI_AWVALID_I = '0, S_AXI_WVALID_I = '0, S_AXI_BREADY_I = '0;
  logic S_AXI_ARVALID_I = '0, S_AXI_RREADY_I = '0, DMA_READY_I = '0, CONV_DONE_I;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic ADC_POWER_O, MOD_CLK_O, DC_CHANNEL_SWITCH_CLOCK_O, ACQUIRE_O, CONV_START_O;
  logic AUDIO_MODE_O, HIGH_INPUT_RANGE_O, RECAL_O, DMA_VALID_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, r;
  logic [3:0] S_AXI_WSTRB_I = 4'hf, PROGRAMMABLE_GAIN_STAGE_O;
  logic [4:0] MUX_SEL_O;
  logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
  logic [8:0] mdel = 9'h1e;
  logic [11:0] DMA_DATA_O, CONV_DATA_I, mval = 12'habc;
  logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O, d;
  int n_errors = 0, tests_run = 0, n_recal = 0;
  row_t rows [5] = '{'{adc_ctrl_pkg::OFF_CHAN, 32'h1f, OK, OK, 32'h1f},
    '{adc_ctrl_pkg::OFF_GAIN, 32'h5, OK, OK, 32'h5}, '{adc_ctrl_pkg::OFF_STATUS, 32'hff, ER, OK, 32'h0},
    '{adc_ctrl_pkg::OFF_RAW, 32'h1, ER, OK, 32'h0}, '{8'h1c, 32'h1, ER, ER, 32'h0}};
  always #25 CLK_I = ~CLK_I;
  always @(posedge CLK_I) if (RECAL_O === 1'b1) n_recal++;
  adc_conversion_control i_dut (.*);
  mod_model i_mod (.clk_i(CLK_I), .start_i(CONV_START_O), .value_i(mval), .delay_i(mdel),
    .done_o(CONV_DONE_I), .data_o(CONV_DATA_I));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ha, hw, hb;
    @(posedge CLK_I);
    {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, v};
    {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'h7;
    forever
    begin
      @(negedge CLK_I);
      ha = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
      hw = S_AXI_WVALID_I & S_AXI_WREADY_O;
      hb = S_AXI_BVALID_O;
      rs = S_AXI_BRESP_O;
      @(posedge CLK_I);
      if (ha) S_AXI_AWVALID_I <= 1'b0;
      if (hw) S_AXI_WVALID_I <= 1'b0;
      if (hb)
      begin
        S_AXI_BREADY_I <= 1'b0;
        return;
      end
    end
  endtask : wr
  // Ready comes a cycle after valid so that a held answer is exercised
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr, hb;
    @(posedge CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    forever
    begin
      @(negedge CLK_I);
      ha = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
      hr = S_AXI_RVALID_O;
      hb = hr & S_AXI_RREADY_I;
      {v, rs} = {S_AXI_RDATA_O, S_AXI_RRESP_O};
      @(posedge CLK_I);
      if (ha) S_AXI_ARVALID_I <= 1'b0;
      if (hb)
      begin
        S_AXI_RREADY_I <= 1'b0;
        return;
      end
      if (hr) S_AXI_RREADY_I <= 1'b1;
    end
  endtask : rd
  initial
  begin
    #1_000_000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    repeat (6) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(negedge CLK_I);
    chk("idle", {S_AXI_BVALID_O, S_AXI_RVALID_O, ADC_POWER_O, DMA_VALID_O}, 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w, r);
      chk("bresp", r, rows[i].b);
      rd(rows[i].a, d, r);
      chk("rdata", d, rows[i].q);
      chk("rresp", r, rows[i].rr);
    end
    chk("gain", PROGRAMMABLE_GAIN_STAGE_O, 32'h5);
    $display("rows done");
    wr(adc_ctrl_pkg::OFF_CTRL, 32'h1, r);
    rd(adc_ctrl_pkg::OFF_RAW, d, r);
    chk("raw", d, {22'h0, mval[11:2]});
    chk("mux", MUX_SEL_O, 32'h1f);
    rd(adc_ctrl_pkg::OFF_VOLT, d, r);
    chk("volt", d, {22'h0, mval[11:2]});
    mdel <= 9'h1c2;
    rd(adc_ctrl_pkg::OFF_RAW, d, r);
    chk("late", d, 32'h0);
    rd(adc_ctrl_pkg::OFF_STATUS, d, r);
    chk("tmo", d[3], 32'h1);
    mdel <= 9'h1e;
    $display("dc done");
    wr(adc_ctrl_pkg::OFF_CTRL, 32'h9, r);
    chk("range", HIGH_INPUT_RANGE_O, 32'h1);
    wr(adc_ctrl_pkg::OFF_CTRL, 32'hf, r);
    for (int n = 0; n < 400 && d[5:4] !== 2'h2; n++) rd(adc_ctrl_pkg::OFF_STATUS, d, r);
    chk("full", d[5:4], 32'h2);
    chk("dmad", {DMA_VALID_O, DMA_DATA_O}, {1'b1, mval});
    DMA_READY_I <= 1'b1;
    wr(adc_ctrl_pkg::OFF_CTRL, 32'h9, r);
    chk("dmaoff", DMA_VALID_O, 32'h0);
    DMA_READY_I <= 1'b0;
    wr(adc_ctrl_pkg::OFF_CTRL, 32'hb, r);
    rd(adc_ctrl_pkg::OFF_AUDIO, d, r);
    chk("audio", d, {20'h0, mval});
    rd(adc_ctrl_pkg::OFF_CTRL, d, r);
    chk("ctrl", {d[30:0], AUDIO_MODE_O}, 32'h17);
    chk("recal", n_recal, 32'h1);
    wr(adc_ctrl_pkg::OFF_CTRL, 32'h0, r);
    rd(adc_ctrl_pkg::OFF_VOLT, d, r);
    chk("off", d, 32'h0);
    $display("audio done");
    // A reset in mid-run must bring the channel register back to its reset value; the range output is already low from the last control write
    RST_B_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    rd(adc_ctrl_pkg::OFF_CHAN, d, r);
    chk("reset", {d[30:0], HIGH_INPUT_RANGE_O}, 32'h0);
    $display("reset done");
    stop_test();
  end
endmodule : tb_top
